// ==== rtl/insn_decoder.sv ====
/*
 * 12-bit instruction decoder and execution sequencer for a small 8-bit
 * core: splits fetched words into fields, picks the result destination,
 * runs one- or two-cycle execution over four-clock instruction cycles.
 * assumes program memory returns the fetched word by the end of a cycle,
 * and the data register file answers the selected address combinationally.
 */
// Function
// - fetch and split 12-bit words into fields
// - classify byte, bit, or literal/control
// - byte class: register selector and destination
// - destination 0 to accumulator, 1 register
// - bit class: bit number and register
// - literal class: 8 or 9 bit constant
// - register addresses span 0x00 to 0x7F
// - one cycle, two for taken skips/branches
// - instruction cycle spans four clock periods
// - PC writes clear bit nine except jump
// - port self-modify reads pin levels
// - timer count modify clears prescaler
`timescale 1ns/10ps
`default_nettype none
module insn_decoder #(
	parameter int FSEL_W = insn_decode_pkg::FSEL_W
) (
	input  wire logic                               clk,
	input  wire logic                               rstn,
	input  wire logic [insn_decode_pkg::INSN_W-1:0] fetch_word,
	input  wire logic [6:0]                         bank_base,
	input  wire logic [insn_decode_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic [insn_decode_pkg::DATA_W-1:0] pin_rdata,
	input  wire logic                               reg_is_port,
	input  wire logic                               skip_true,
	input  wire logic [insn_decode_pkg::PC_W-1:0]   stack_top,
	input  wire logic                               prescaler_on_timer,
	output logic [insn_decode_pkg::PC_W-1:0]        pc,
	output logic [insn_decode_pkg::INSN_W-1:0]      exec_word,
	output logic [1:0]                              insn_class,
	output logic [FSEL_W-1:0]                       reg_addr,
	output logic                                    dest_reg,
	output logic                                    wr_accum,
	output logic                                    wr_reg,
	output logic [2:0]                              bit_num,
	output logic [8:0]                              literal,
	output logic [insn_decode_pkg::DATA_W-1:0]      src_operand,
	output logic                                    prescaler_clr,
	output logic                                    idle_cycle,
	output logic [1:0]                              phase
);
	// refuse a selector width the bank merge cannot serve
	if (FSEL_W != 7) begin : g_bad_fsel
		$error("insn_decoder: selector must be 7 bits");
	end

	localparam int PW = insn_decode_pkg::PC_W;

	// class of a word from its top bits
	function automatic logic [1:0] classify(input logic [11:0] w);
		logic [1:0] c;
		c = insn_decode_pkg::CLS_LIT;
		if (w[11:10] == insn_decode_pkg::GRP_BYTE)
			c = insn_decode_pkg::CLS_BYTE;
		else if (w[11:10] == insn_decode_pkg::GRP_BIT)
			c = insn_decode_pkg::CLS_BIT;
		return c;
	endfunction

	logic [1:0]  ph;
	logic        cyc_start;
	logic        cyc_end;

	// four clocks make one instruction cycle
	phase_divider #(
		.PHASES      (insn_decode_pkg::PHASES)
	) u_phase (
		.clk         (clk),
		.rstn        (rstn),
		.phase       (ph),
		.cycle_start (cyc_start),
		.cycle_end   (cyc_end)
	);

	logic [PW-1:0] pc_ff;
	logic [11:0]   exec_ff;
	logic          idle_ff;
	logic [1:0]    class_ff;
	logic [6:0]    addr_ff;
	logic          dest_ff;
	logic          wr_acc_ff;
	logic          wr_reg_ff;
	logic [2:0]    bit_ff;
	logic [8:0]    lit_ff;
	logic [7:0]    src_ff;
	logic          pclr_ff;
	logic [1:0]    phase_ff;

	// decode of the word now executing
	logic [1:0]  cls;
	logic [5:0]  op6;
	logic [4:0]  f5;
	logic        is_jump;
	logic        is_call;
	logic        is_retlw;
	logic        is_ret;
	logic        is_skip;
	logic        pcl_write;
	logic        redirect;
	logic        writes;
	logic [PW-1:0] nxt_pc;

	always_comb begin
		cls      = classify(exec_ff);
		op6      = exec_ff[11:6];
		f5       = exec_ff[4:0];
		is_jump  = exec_ff[11:9] == insn_decode_pkg::OP_JUMP;
		is_call  = exec_ff[11:8] == insn_decode_pkg::OP_CALL;
		is_retlw = exec_ff[11:8] == insn_decode_pkg::OP_RETLW;
		is_ret   = exec_ff == insn_decode_pkg::INSN_RETURN
			|| exec_ff == insn_decode_pkg::INSN_RETFIE;
		is_skip  = op6 == insn_decode_pkg::OP_DECFSZ
			|| op6 == insn_decode_pkg::OP_INCFSZ
			|| (cls == insn_decode_pkg::CLS_BIT
			&& exec_ff[9] == 1'b1);
		writes   = (cls == insn_decode_pkg::CLS_BYTE && exec_ff[5]
			&& op6 != insn_decode_pkg::OP_MISC)
			|| (cls == insn_decode_pkg::CLS_BYTE
			&& op6 == insn_decode_pkg::OP_MOVWF && exec_ff[5])
			|| (cls == insn_decode_pkg::CLS_BIT && !exec_ff[9]);
		pcl_write = writes && f5 == insn_decode_pkg::ADDR_PCL;
		redirect = is_jump || is_call || is_retlw || is_ret
			|| pcl_write || (is_skip && skip_true);
	end

	// next program counter; jump keeps the page bit, other writes clear it
	always_comb begin
		nxt_pc = pc_ff + 10'h001;
		if (is_jump)
			nxt_pc = {pc_ff[PW-1], exec_ff[8:0]};
		else if (is_call)
			nxt_pc = {2'b00, exec_ff[7:0]};
		else if (is_retlw || is_ret)
			nxt_pc = {1'b0, stack_top[8:0]};
		else if (pcl_write)
			nxt_pc = {1'b0, pc_ff[8], reg_rdata};
		else if (is_skip && skip_true)
			nxt_pc = pc_ff + 10'h001;
	end

	// program counter steps once per instruction cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pc_ff <= insn_decode_pkg::PC_RESET;
		end else if (cyc_end && !idle_ff) begin
			pc_ff <= nxt_pc;
		end else if (cyc_end) begin
			pc_ff <= pc_ff + 10'h001;
		end
	end

	// latch prefetched word; a redirect flushes it to an idle cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			exec_ff <= insn_decode_pkg::INSN_NOP;
			idle_ff <= 1'b1;
		end else if (cyc_end) begin
			if (!idle_ff && redirect) begin
				exec_ff <= insn_decode_pkg::INSN_NOP;
				idle_ff <= 1'b1;
			end else begin
				exec_ff <= fetch_word;
				idle_ff <= 1'b0;
			end
		end
	end

	// field extraction, registered at the start of each cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			class_ff  <= insn_decode_pkg::CLS_BYTE;
			addr_ff   <= 7'h00;
			dest_ff   <= 1'b0;
			bit_ff    <= 3'h0;
			lit_ff    <= 9'h000;
		end else if (cyc_start) begin
			class_ff <= cls;
			addr_ff  <= bank_base | {2'b00, f5};
			dest_ff  <= exec_ff[insn_decode_pkg::DEST_BIT];
			bit_ff   <= exec_ff[7:5];
			lit_ff   <= is_jump ? exec_ff[8:0]
				: {1'b0, exec_ff[7:0]};
		end
	end

	// destination strobes in the last phase of a real instruction
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_acc_ff <= 1'b0;
			wr_reg_ff <= 1'b0;
		end else begin
			wr_acc_ff <= ph == 2'h2 && !idle_ff
				&& cls == insn_decode_pkg::CLS_BYTE
				&& !exec_ff[5] && op6 != insn_decode_pkg::OP_MISC;
			wr_reg_ff <= ph == 2'h2 && !idle_ff && writes;
		end
	end

	// source operand: pins for port registers, else file data
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			src_ff <= 8'h00;
		end else if (ph == 2'h1) begin
			src_ff <= reg_is_port ? pin_rdata : reg_rdata;
		end
	end

	// prescaler clear when a modify lands on the timer count
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pclr_ff <= 1'b0;
		end else begin
			pclr_ff <= ph == 2'h2 && !idle_ff && writes
				&& f5 == insn_decode_pkg::ADDR_TIMER_ZERO_COUNT
				&& prescaler_on_timer;
		end
	end

	// phase mirror for the outside
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase_ff <= insn_decode_pkg::PHASE_RST;
		end else begin
			phase_ff <= ph;
		end
	end

	assign pc            = pc_ff;
	assign exec_word     = exec_ff;
	assign insn_class    = class_ff;
	assign reg_addr      = addr_ff;
	assign dest_reg      = dest_ff;
	assign wr_accum      = wr_acc_ff;
	assign wr_reg        = wr_reg_ff;
	assign bit_num       = bit_ff;
	assign literal       = lit_ff;
	assign src_operand   = src_ff;
	assign prescaler_clr = pclr_ff;
	assign idle_cycle    = idle_ff;
	assign phase         = phase_ff;
endmodule // insn_decoder
`default_nettype wire

// ==== rtl/insn_decode_pkg.sv ====
/*
 * constants for the 12-bit instruction decoder and execution sequencer:
 * field positions, opcode patterns, phase codes and reset values.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package insn_decode_pkg;

	localparam int INSN_W      = 12;
	localparam int DATA_W      = 8;
	localparam int PC_W        = 10;
	localparam int FSEL_W      = 7;
	localparam int PHASES      = 4;

	// field positions inside the instruction word
	localparam int FSEL_LSB    = 0;
	localparam int FLD5_W      = 5;
	localparam int DEST_BIT    = 5;
	localparam int BITNUM_LSB  = 5;
	localparam int BITNUM_W    = 3;
	localparam int K8_LSB      = 0;
	localparam int K9_W        = 9;
	localparam int PC_HI_BIT   = 9;

	// opcode groups on the top bits
	localparam logic [1:0] GRP_BYTE   = 2'h0;
	localparam logic [1:0] GRP_BIT    = 2'h1;
	localparam logic [3:0] OP_RETLW   = 4'h8;
	localparam logic [3:0] OP_CALL    = 4'h9;
	localparam logic [2:0] OP_JUMP    = 3'h5;
	localparam logic [5:0] OP_DECFSZ  = 6'h0B;
	localparam logic [5:0] OP_INCFSZ  = 6'h0F;
	localparam logic [5:0] OP_MOVWF   = 6'h00;
	localparam logic [5:0] OP_CLRF    = 6'h01;
	localparam logic [5:0] OP_MISC    = 6'h00;
	localparam logic [1:0] OP_BTFSC   = 2'h2;
	localparam logic [1:0] OP_BTFSS   = 2'h3;
	localparam logic [11:0] INSN_RETFIE = 12'h01F;
	localparam logic [11:0] INSN_RETURN = 12'h01E;
	localparam logic [11:0] INSN_NOP    = 12'h000;

	// special register addresses (low five bits)
	localparam logic [4:0] ADDR_PCL   = 5'h02;
	localparam logic [4:0] ADDR_TIMER_ZERO_COUNT  = 5'h01;

	localparam logic [PC_W-1:0]  PC_RESET  = 10'h3FF;
	localparam logic [1:0]       PHASE_RST = 2'h0;

	typedef enum logic [1:0] {
		CLS_BYTE = 2'b00,
		CLS_BIT  = 2'b01,
		CLS_LIT  = 2'b10
	} insn_class_type;

endpackage

// ==== rtl/phase_divider.sv ====
/*
 * divides the core clock into four phases and marks the first and last
 * phase of each instruction cycle with one-cycle pulses.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module phase_divider #(
	parameter int PHASES = insn_decode_pkg::PHASES
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	output logic [1:0]      phase,
	output logic            cycle_start,
	output logic            cycle_end
);
	// refuse a phase count the two-bit counter cannot serve
	if (PHASES != 4) begin : g_bad_phases
		$error("phase_divider: only four phases supported");
	end

	logic [1:0] phase_ff;

	// free-running phase counter, one instruction cycle per wrap
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase_ff <= insn_decode_pkg::PHASE_RST;
		end else begin
			phase_ff <= phase_ff + 2'h1;
		end
	end

	assign phase       = phase_ff;
	assign cycle_start = (phase_ff == 2'h0);
	assign cycle_end   = (phase_ff == 2'h3);
endmodule // phase_divider
`default_nettype wire

// ==== verif/insn_decoder_checker.sv ====
/*
 * port checker for the instruction decoder: phase stepping, field
 * extraction, destination pulses and idle cycles.
 * bound to insn_decoder from the bench top; one clock, reset low.
 */
`timescale 1ns/10ps
`default_nettype none
module insn_decoder_checker #(
	parameter int FSEL_W = 7
) (
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic [11:0]       exec_word,
	input wire logic [1:0]        insn_class,
	input wire logic [FSEL_W-1:0] reg_addr,
	input wire logic              dest_reg,
	input wire logic              wr_accum,
	input wire logic              wr_reg,
	input wire logic [2:0]        bit_num,
	input wire logic [8:0]        literal,
	input wire logic              prescaler_clr,
	input wire logic              idle_cycle,
	input wire logic [1:0]        phase
);
	logic [11:0] last_ff;
	logic [1:0]  age_ff;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// edges since the executing word last changed, saturating at 3;
	// at 2 the sampled word and its registered fields line up
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			last_ff <= 12'h000;
			age_ff  <= 2'h0;
		end else begin
			last_ff <= exec_word;
			if (exec_word != last_ff)
				age_ff <= 2'h0;
			else if (age_ff != 2'h3)
				age_ff <= age_ff + 2'h1;
		end
	end

	sequence quiet3;
		(!wr_accum && !wr_reg) [*3];
	endsequence

	AST_PHASE_STEP: assert property (
		$past(rstn, 2) |-> phase == $past(phase) + 2'h1)
		else $error("phase did not step by one");
	AST_CLASS_LEGAL: assert property (insn_class != 2'h3)
		else $error("instruction class out of range");
	AST_ACC_DEST: assert property (
		wr_accum && insn_class == insn_decode_pkg::CLS_BYTE |-> !dest_reg)
		else $error("accumulator write with destination set");
	AST_REG_DEST: assert property (
		wr_reg && insn_class == insn_decode_pkg::CLS_BYTE |-> dest_reg)
		else $error("register write with destination clear");
	AST_PULSE_ONE: assert property (wr_accum || wr_reg |=> quiet3)
		else $error("second write within one instruction cycle");
	AST_IDLE_SPAN: assert property (
		$rose(idle_cycle) |-> idle_cycle [*4])
		else $error("idle cycle shorter than four clocks");
	AST_IDLE_QUIET: assert property (
		idle_cycle && $past(idle_cycle)
		|-> !wr_accum && !wr_reg && !prescaler_clr)
		else $error("side effect during idle cycle");
	AST_BIT_FIELD: assert property (
		age_ff == 2'h2 && exec_word[11:10] == 2'h1
		|-> insn_class == 2'h1 && bit_num == exec_word[7:5])
		else $error("bit number field wrong");
	AST_LIT_FIELD: assert property (
		age_ff == 2'h2 && exec_word[11:9] == 3'h5
		|-> insn_class == 2'h2 && literal == exec_word[8:0])
		else $error("nine bit constant wrong");
	AST_BYTE_FIELD: assert property (
		age_ff == 2'h2 && exec_word[11:10] == 2'h0
		&& exec_word[9:6] != 4'h0
		|-> reg_addr[4:0] == exec_word[4:0] && dest_reg == exec_word[5])
		else $error("register selector or destination wrong");
endmodule // insn_decoder_checker
`default_nettype wire

// ==== verif/prog_regfile_model.sv ====
/*
 * program memory and data register file seen by the decoder.
 * the bench loads mem before reset; reads answer combinationally.
 */
`timescale 1ns/10ps
`default_nettype none
module prog_regfile_model #(
	parameter logic [4:0] PORT_ADDR = 5'h06
) (
	input  wire logic [9:0]  pc,
	input  wire logic [6:0]  reg_addr,
	output logic [11:0]      fetch_word,
	output logic [7:0]       reg_rdata,
	output logic [7:0]       pin_rdata,
	output logic             reg_is_port
);
	logic [11:0] mem [0:1023];

	// latch and pin values differ so a wrong source shows up
	always_comb begin
		fetch_word  = mem[pc];
		reg_rdata   = {1'b0, reg_addr} ^ 8'h5A;
		pin_rdata   = ~{1'b0, reg_addr};
		reg_is_port = (reg_addr[4:0] == PORT_ADDR);
	end
endmodule // prog_regfile_model
`default_nettype wire

// ==== verif/test_insn_decoder.sv ====
/*
 * self-checking bench for the instruction decoder: runs one short
 * program of jump, byte, bit, literal, call, skip and return words.
 * assumes the checker and the memory model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
	cmp_count++; \
	if ((a) !== (b)) begin \
		num_errors++; \
		$display("[ERR] %0t got %h exp %h", $time, a, b); \
	end \
end
module test_insn_decoder;
	logic clk, rstn, skip_true, prescaler_on_timer, reg_is_port;
	logic dest_reg, wr_accum, wr_reg, prescaler_clr, idle_cycle;
	logic [11:0] fetch_word, exec_word;
	logic [9:0]  stack_top, pc;
	logic [7:0]  reg_rdata, pin_rdata, src_operand;
	logic [6:0]  bank_base, reg_addr;
	logic [8:0]  literal, s_lit;
	logic [2:0]  bit_num, s_bn;
	logic [1:0]  insn_class, phase, s_cls;
	logic [6:0]  s_adr;
	logic [7:0]  s_src;
	logic        s_d, f_acc, f_reg, f_clr, f_idl;
	int          num_errors = 0;
	int          cmp_count = 0;

	insn_decoder u_insn_decoder (.clk(clk), .rstn(rstn),
		.fetch_word(fetch_word), .bank_base(bank_base),
		.reg_rdata(reg_rdata), .pin_rdata(pin_rdata),
		.reg_is_port(reg_is_port), .skip_true(skip_true),
		.stack_top(stack_top), .prescaler_on_timer(prescaler_on_timer),
		.pc(pc), .exec_word(exec_word), .insn_class(insn_class),
		.reg_addr(reg_addr), .dest_reg(dest_reg), .wr_accum(wr_accum),
		.wr_reg(wr_reg), .bit_num(bit_num), .literal(literal),
		.src_operand(src_operand), .prescaler_clr(prescaler_clr),
		.idle_cycle(idle_cycle), .phase(phase));
	prog_regfile_model u_prog_regfile_model (.pc(pc), .reg_addr(reg_addr),
		.fetch_word(fetch_word), .reg_rdata(reg_rdata),
		.pin_rdata(pin_rdata), .reg_is_port(reg_is_port));

	// clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task complete_run;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// wait for a word to execute, collect its pulses and fields
	task automatic run(input logic [11:0] w);
		int n;
		n = 0;
		f_idl = 1'b0;
		while (!(exec_word === w && idle_cycle === 1'b0) && n < 80) begin
			@(negedge clk);
			f_idl |= (idle_cycle === 1'b1);
			n++;
		end
		`CHK(exec_word, w)
		{f_acc, f_reg, f_clr} = 3'h0;
		for (int i = 1; i <= 4; i++) begin
			@(negedge clk);
			f_acc |= wr_accum;
			f_reg |= wr_reg;
			f_clr |= prescaler_clr;
			if (i == 3)
				{s_cls, s_adr, s_d, s_bn, s_lit, s_src} = {insn_class,
					reg_addr, dest_reg, bit_num, literal, src_operand};
		end
	endtask

	task t_jump;
		run(12'hBF0);
		`CHK({s_cls, s_lit}, 11'h5F0)
	endtask

	task t_byte;
		run(12'h1E5);
		`CHK(f_idl, 1'b1)
		`CHK(s_adr, 7'h65)
		`CHK({s_d, f_reg, f_acc}, 3'h6)
		run(12'h1C5);
		`CHK(f_idl, 1'b0)
		`CHK({s_cls, s_d, f_reg, f_acc}, 5'h01)
	endtask

	task t_bit_lit;
		run(12'h5E3);
		`CHK({s_cls, s_bn, s_adr}, 12'h7E3)
		run(12'hCC3);
		`CHK({s_cls, s_lit}, 11'h4C3)
	endtask

	task t_call_port;
		run(12'h940);
		run(12'h221);
		`CHK({f_idl, f_clr}, 2'h3)
		run(12'h226);
		`CHK(s_src, 8'h99)
		`CHK(f_clr, 1'b0)
	endtask

	task t_skip_ret;
		@(posedge clk) skip_true <= 1'b1;
		@(negedge clk);
		run(12'h2E8);
		@(posedge clk) skip_true <= 1'b0;
		run(12'h855);
		`CHK(f_idl, 1'b1)
		for (int i = 0; i < 12 && pc !== 10'h1A0; i++)
			@(negedge clk);
		`CHK(pc, 10'h1A0)
		@(posedge clk) prescaler_on_timer <= 1'b0;
		run(12'h221);
		`CHK({f_reg, f_clr}, 2'h2)
	endtask

	// program, reset, scenarios
	initial begin
		rstn = 1'b0;
		skip_true = 1'b0;
		prescaler_on_timer = 1'b1;
		bank_base = 7'h60;
		stack_top = 10'h3A0;
		for (int i = 0; i < 1024; i++)
			u_prog_regfile_model.mem[i] = 12'h000;
		u_prog_regfile_model.mem[10'h3FF] = 12'hBF0;
		u_prog_regfile_model.mem[10'h1F0] = 12'h1E5;
		u_prog_regfile_model.mem[10'h1F1] = 12'h1C5;
		u_prog_regfile_model.mem[10'h1F2] = 12'h5E3;
		u_prog_regfile_model.mem[10'h1F3] = 12'hCC3;
		u_prog_regfile_model.mem[10'h1F4] = 12'h940;
		u_prog_regfile_model.mem[10'h040] = 12'h221;
		u_prog_regfile_model.mem[10'h041] = 12'h226;
		u_prog_regfile_model.mem[10'h042] = 12'h2E8;
		u_prog_regfile_model.mem[10'h043] = 12'h1E5;
		u_prog_regfile_model.mem[10'h044] = 12'h855;
		u_prog_regfile_model.mem[10'h1A0] = 12'h221;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		t_jump;
		t_byte;
		t_bit_lit;
		t_call_port;
		t_skip_ret;
		complete_run;
	end

	// watchdog
	initial begin
		#5000;
		num_errors++;
		complete_run;
	end
endmodule // test_insn_decoder

bind insn_decoder insn_decoder_checker #(.FSEL_W(FSEL_W))
	u_insn_decoder_checker (.clk(clk), .rstn(rstn), .exec_word(exec_word),
	.insn_class(insn_class), .reg_addr(reg_addr), .dest_reg(dest_reg),
	.wr_accum(wr_accum), .wr_reg(wr_reg), .bit_num(bit_num),
	.literal(literal), .prescaler_clr(prescaler_clr),
	.idle_cycle(idle_cycle), .phase(phase));
`default_nettype wire
